// file: core/tmr_pair.sv
`timescale 1ns/1ps
// Behaviour
// - each compare register is compared with its count register at every count step
// - in separate mode, equality raises that channel's match interrupt
// - separate mode compare accepts any 8-bit value
// - cascaded mode compares one 16-bit value from both registers
// - compare registers load only on byte-wide writes
// - compare registers are not reset
// - each count register increments once per selected count pulse, except the cascaded high byte, which steps on low-byte wrap
// - both count registers clear to zero on reset
// - separate mode reads each count as a byte
// - cascaded mode reads the 16-bit count in one access
// - interval mode interrupts each time the compare interval elapses
// - cascaded interval resolution is one count period, up to 65536
// - separate square wave toggles at match, half period 1 to 256
// - cascaded square wave half period up to 65536 count periods
// - event mode counts valid edges of the external pulse input
// - two counts, two compares and two wave outputs
// - four-bit select picks input edge or main clock division
// - first channel enable starts and stops the cascaded pair
module tmr_pair
    import tmr_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         pulse_in_first,
    input  wire logic         pulse_in_second,
    output logic              match_irq_first,
    output logic              match_irq_second,
    output logic              wave_out_first,
    output logic              wave_out_second
);
    import tmr_pkg::*;

    chan_if ch_first ();
    chan_if ch_second ();

    tmr_channel u_first (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch_first)
    );
    tmr_channel u_second (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch_second)
    );

    logic [7:0] compare_reg_first;
    logic [7:0] compare_reg_second;
    logic [7:0] count_clock_select_reg;
    logic [7:0] timer_mode_ctrl_reg;
    logic [7:0] timer_output_ctrl_reg;
    logic [1:0] in_first_sync;
    logic [1:0] in_second_sync;
    logic       in_first_prev;
    logic       in_second_prev;
    logic [PRESCALE_BITS-1:0] prescale;
    logic [PRESCALE_BITS-1:0] prescale_prev;
    logic       wave_first;
    logic       wave_second;
    logic       irq_first_q;
    logic       irq_second_q;

    // count source decode, shared by both channels
    function automatic logic pick_tick(
        input logic [3:0]               sel,
        input logic                     rise,
        input logic                     fall,
        input logic [PRESCALE_BITS-1:0] fell
    );
        logic t;
        t = 1'b0;
        case (sel)
            4'h0:    t = fall;
            4'h1:    t = rise;
            4'h6:    t = fell[1];
            4'h7:    t = fell[2];
            4'h8:    t = fell[3];
            4'h9:    t = fell[4];
            4'ha:    t = fell[5];
            4'hb:    t = fell[6];
            4'hc:    t = fell[7];
            4'hd:    t = fell[8];
            4'he:    t = fell[9];
            4'hf:    t = fell[11];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // bus decode
    // only aligned word offsets hit; any other byte address is unmapped
    wire        wr_access  = psel & penable & pwrite;
    wire        byte_write = (pstrb == 4'h1);
    wire        hit_cmp1   = (paddr == OFS_COMPARE_FIRST);
    wire        hit_cmp2   = (paddr == OFS_COMPARE_SECOND);
    wire        hit_cnt1   = (paddr == OFS_COUNT_FIRST);
    wire        hit_cnt2   = (paddr == OFS_COUNT_SECOND);
    wire        hit_cnts   = (paddr == OFS_COUNT_COMBINED);
    wire        hit_csel   = (paddr == OFS_CLOCK_SELECT);
    wire        hit_mode   = (paddr == OFS_MODE_CTRL);
    wire        hit_outc   = (paddr == OFS_OUTPUT_CTRL);
    wire        hit_stat   = (paddr == OFS_STATUS);
    wire        mapped     = hit_cmp1 | hit_cmp2 | hit_cnt1 | hit_cnt2 | hit_cnts
                           | hit_csel | hit_mode | hit_outc | hit_stat;
    // a wider write to a compare register is refused
    wire        cmp_bad    = pwrite & (hit_cmp1 | hit_cmp2) & ~byte_write;
    wire        wr_ok      = wr_access & mapped & ~cmp_bad;
    wire        wr_cmp1    = wr_ok & hit_cmp1;
    wire        wr_cmp2    = wr_ok & hit_cmp2;
    // the reply is built at setup so that it stands through the access phase
    wire        setup_phase = psel & ~penable;
    wire        ro_write    = pwrite & (hit_cnt1 | hit_cnt2 | hit_cnts | hit_stat);
    wire        refuse      = ~mapped | cmp_bad | ro_write;

    // mode decode
    wire        cascade   = timer_mode_ctrl_reg[MODE_CASCADE];
    // first enable runs both halves when cascaded
    wire        run_first  = timer_mode_ctrl_reg[MODE_ENABLE_FIRST];
    // stopping the first half in cascade also freezes the carry into the second
    wire        run_second = cascade ? run_first
                                     : timer_mode_ctrl_reg[MODE_ENABLE_SECOND];
    wire        clr_first  = timer_mode_ctrl_reg[MODE_CLEAR_FIRST];
    wire        clr_second = timer_mode_ctrl_reg[MODE_CLEAR_SECOND];

    // prescaler taps fire on the falling edge of each bit
    // the divider runs free, so the first period after a start may be short
    wire [PRESCALE_BITS-1:0] div_fell = prescale_prev & ~prescale;

    // external edges, after two-stage sync
    // a pulse level held for less than one clock may be missed
    wire        rise_first  = in_first_sync[1] & ~in_first_prev;
    wire        fall_first  = ~in_first_sync[1] & in_first_prev;
    wire        rise_second = in_second_sync[1] & ~in_second_prev;
    wire        fall_second = ~in_second_sync[1] & in_second_prev;

    wire        tick_first  = pick_tick(count_clock_select_reg[CSEL_FIRST_LSB +: 4],
                                        rise_first, fall_first, div_fell);
    wire        tick_second_sep = pick_tick(count_clock_select_reg[CSEL_SECOND_LSB +: 4],
                                            rise_second, fall_second, div_fell);

    // cascaded high byte steps on low-byte wrap
    wire        tick_second = cascade ? ch_first.wrap : tick_second_sep;

    // 16-bit match needs both halves equal at a low-byte step
    // resolution of one count period, up to 65536 periods
    wire [15:0] count16    = {ch_second.count, ch_first.count};
    wire [15:0] compare16  = {compare_reg_second, compare_reg_first};
    wire        match16    = run_first & tick_first & (count16 == compare16);

    wire        event_first  = cascade ? match16 : (run_first & tick_first
                               & (ch_first.count == compare_reg_first));
    // in cascade the pair reports through the first interrupt only
    wire        event_second = cascade ? 1'b0 : ch_second.match;
    wire        first_hit_sep = ch_first.match & ~cascade;

    // clear after match, whole pair together when cascaded
    // the clear lands one clock after the match, so a tick in that clock is lost
    wire        cascade_clear = cascade & clr_first & irq_first_q;
    wire        clear_first_sep  = ~cascade & clr_first & first_hit_sep;
    wire        clear_second_sep = ~cascade & clr_second & ch_second.match;

    assign ch_first.tick     = tick_first;
    assign ch_first.run      = run_first;
    assign ch_first.compare  = compare_reg_first;
    assign ch_first.clear    = cascade_clear | clear_first_sep;
    assign ch_second.tick    = tick_second;
    assign ch_second.run     = run_second;
    assign ch_second.compare = compare_reg_second;
    assign ch_second.clear   = cascade_clear | clear_second_sep;

    // read mux
    wire [7:0]  status_bits = {4'h0, wave_second, wave_first, irq_second_q, irq_first_q};
    wire [31:0] rd_mux =
          hit_cmp1 ? {24'h0, compare_reg_first}
        : hit_cmp2 ? {24'h0, compare_reg_second}
        : hit_cnt1 ? {24'h0, ch_first.count}
        : hit_cnt2 ? {24'h0, ch_second.count}
        : hit_cnts ? {16'h0, count16}
        : hit_csel ? {24'h0, count_clock_select_reg}
        : hit_mode ? {24'h0, timer_mode_ctrl_reg}
        : hit_outc ? {24'h0, timer_output_ctrl_reg}
        : hit_stat ? {24'h0, status_bits}
        : 32'h0;

    // compares take the full byte range
    // no reset here: contents stay undefined until written, saving reset fan-out
    always_ff @(posedge pclk)
    begin
        if (wr_cmp1)
            compare_reg_first <= pwdata[7:0];
        if (wr_cmp2)
            compare_reg_second <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_clock_select_reg <= RST_CLOCK_SELECT;
            timer_mode_ctrl_reg    <= RST_MODE_CTRL;
            timer_output_ctrl_reg  <= RST_OUTPUT_CTRL;
        end
        else if (wr_ok)
        begin
            if (hit_csel)
                count_clock_select_reg <= pwdata[7:0];
            if (hit_mode)
                timer_mode_ctrl_reg <= pwdata[7:0];
            if (hit_outc)
                timer_output_ctrl_reg <= pwdata[7:0];
        end
    end

    // zero-wait apb answer in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup_phase;
            pslverr <= setup_phase & refuse;
            prdata  <= (setup_phase & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // synchronisers and prescaler
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_first_sync  <= 2'b00;
            in_second_sync <= 2'b00;
            in_first_prev  <= 1'b0;
            in_second_prev <= 1'b0;
            prescale       <= '0;
            prescale_prev  <= '0;
        end
        else
        begin
            in_first_sync  <= {in_first_sync[0], pulse_in_first};
            in_second_sync <= {in_second_sync[0], pulse_in_second};
            in_first_prev  <= in_first_sync[1];
            in_second_prev <= in_second_sync[1];
            prescale       <= prescale + 1'b1;
            prescale_prev  <= prescale;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_first_q  <= 1'b0;
            irq_second_q <= 1'b0;
        end
        else
        begin
            irq_first_q  <= event_first;
            irq_second_q <= event_second;
        end
    end

    // wave flip-flops toggle on match, set and reset by software
    wire        out_wr      = wr_ok & hit_outc;
    wire [7:0]  oc          = pwdata[7:0];
    // a software set or reset in the same clock as a match wins over the toggle
    wire        set_first   = out_wr & oc[OUT_SET];
    wire        rst_first   = out_wr & oc[OUT_RESET];
    wire        set_second  = out_wr & oc[OUT_SECOND_BASE + OUT_SET];
    wire        rst_second  = out_wr & oc[OUT_SECOND_BASE + OUT_RESET];
    wire        flip_first  = irq_first_q & timer_output_ctrl_reg[OUT_TOGGLE];
    // the cascaded pair flips the second output on the 16-bit match
    wire        flip_second = (cascade ? irq_first_q : irq_second_q)
                              & timer_output_ctrl_reg[OUT_SECOND_BASE + OUT_TOGGLE];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wave_first  <= 1'b0;
            wave_second <= 1'b0;
        end
        else
        begin
            if (set_first)
                wave_first <= 1'b1;
            else if (rst_first)
                wave_first <= 1'b0;
            else if (flip_first)
                wave_first <= ~wave_first;
            if (set_second)
                wave_second <= 1'b1;
            else if (rst_second)
                wave_second <= 1'b0;
            else if (flip_second)
                wave_second <= ~wave_second;
        end
    end

    // a disabled output rests low while its flip-flop keeps toggling behind it
    wire        oe_first  = timer_output_ctrl_reg[OUT_ENABLE];
    wire        oe_second = timer_output_ctrl_reg[OUT_SECOND_BASE + OUT_ENABLE];

    // two gated wave outputs and interrupts, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wave_out_first   <= 1'b0;
            wave_out_second  <= 1'b0;
            match_irq_first  <= 1'b0;
            match_irq_second <= 1'b0;
        end
        else
        begin
            wave_out_first   <= wave_first & oe_first;
            wave_out_second  <= wave_second & oe_second;
            match_irq_first  <= irq_first_q;
            match_irq_second <= irq_second_q;
        end
    end
endmodule // tmr_pair

// file: common/tmr_pkg.sv
package tmr_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_COMPARE_FIRST  = 8'h00;
    localparam logic [7:0] OFS_COMPARE_SECOND = 8'h04;
    localparam logic [7:0] OFS_COUNT_FIRST    = 8'h08;
    localparam logic [7:0] OFS_COUNT_SECOND   = 8'h0c;
    localparam logic [7:0] OFS_COUNT_COMBINED = 8'h10;
    localparam logic [7:0] OFS_CLOCK_SELECT   = 8'h14;
    localparam logic [7:0] OFS_MODE_CTRL      = 8'h18;
    localparam logic [7:0] OFS_OUTPUT_CTRL    = 8'h1c;
    localparam logic [7:0] OFS_STATUS         = 8'h20;

    // reset values
    localparam logic [7:0] RST_COUNT        = 8'h00;
    localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] RST_MODE_CTRL    = 8'h00;
    localparam logic [7:0] RST_OUTPUT_CTRL  = 8'h00;

    // clock select: [3:0] first channel, [7:4] second channel
    localparam int CSEL_FIRST_LSB  = 0;
    localparam int CSEL_SECOND_LSB = 4;
    localparam logic [3:0] CSEL_FALLING = 4'h0;
    localparam logic [3:0] CSEL_RISING  = 4'h1;

    // mode control bits
    localparam int MODE_ENABLE_FIRST  = 0;
    localparam int MODE_ENABLE_SECOND = 1;
    localparam int MODE_CASCADE       = 2;
    localparam int MODE_CLEAR_FIRST   = 3;
    localparam int MODE_CLEAR_SECOND  = 4;

    // output control bits, per channel at base 0 and 4
    localparam int OUT_ENABLE = 0;
    localparam int OUT_TOGGLE = 1;
    localparam int OUT_SET    = 2;
    localparam int OUT_RESET  = 3;
    localparam int OUT_SECOND_BASE = 4;

    // prescaler width: main clock divided by up to 2^12
    localparam int PRESCALE_BITS = 12;

    // timing: clock rate and a documented count-clock figure
    localparam int  CLOCK_HZ         = 40_000_000;
    localparam real FASTEST_TICK_NS  = 400.0;
    localparam int  FASTEST_TICK_CYC =
        (int'(FASTEST_TICK_NS * CLOCK_HZ / 1.0e9) < 1) ? 1
        : int'(FASTEST_TICK_NS * CLOCK_HZ / 1.0e9);

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_SETUP  = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_phase_e;
endpackage

// file: common/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
    logic       tick;
    logic       clear;
    logic       run;
    logic [7:0] compare;
    logic [7:0] count;
    logic       match;
    logic       wrap;

    modport ctrl (output tick, output clear, output run, output compare,
                  input count, input match, input wrap);
    modport chan (input tick, input clear, input run, input compare,
                  output count, output match, output wrap);
endinterface

// file: core/tmr_channel.sv
`timescale 1ns/1ps
module tmr_channel
    import tmr_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    chan_if.chan      ch
);
    logic [7:0] count;
    logic       match_q;

    assign ch.count = count;
    assign ch.match = match_q;
    assign ch.wrap  = ch.tick & ch.run & (count == 8'hff);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count   <= RST_COUNT;
            match_q <= 1'b0;
        end
        else
        begin
            match_q <= ch.run & ch.tick & (count == ch.compare);
            if (ch.clear)
                count <= RST_COUNT;
            else if (ch.run && ch.tick)
                count <= count + 8'h01;
        end
    end
endmodule // tmr_channel

// file: sim/tmr_pair_sva.sv
`timescale 1ns/1ps
module tmr_pair_sva
    import tmr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pulse_in_first,
    input wire logic        pulse_in_second,
    input wire logic        match_irq_first,
    input wire logic        match_irq_second,
    input wire logic        wave_out_first,
    input wire logic        wave_out_second
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc_w = psel && penable && pwrite && pready;
    wire cmp_a = paddr == OFS_COMPARE_FIRST || paddr == OFS_COMPARE_SECOND;
    wire cnt_a = paddr == OFS_COUNT_FIRST || paddr == OFS_COUNT_SECOND
                 || paddr == OFS_COUNT_COMBINED;

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    strobe_refuse_a: assert property (acc_w && cmp_a && pstrb != 4'h1 |-> pslverr)
        else $error("wide compare write accepted");
    byte_write_ok_a: assert property (acc_w && cmp_a && pstrb == 4'h1 |-> !pslverr)
        else $error("byte compare write refused");
    count_readonly_a: assert property (acc_w && cnt_a |-> pslverr)
        else $error("count write accepted");
    unmapped_read_a: assert property (psel && penable && pready && paddr > OFS_STATUS
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    irq_first_pulse_a: assert property (match_irq_first |=> !match_irq_first)
        else $error("first match irq longer than a cycle");
    irq_second_pulse_a: assert property (match_irq_second |=> !match_irq_second)
        else $error("second match irq longer than a cycle");
    reset_quiet_a: assert property ($rose(presetn) |-> !(match_irq_first
        || match_irq_second || wave_out_first || wave_out_second))
        else $error("outputs active after reset");
    wave_on_match_a: assert property ($changed(wave_out_first) && !$past(acc_w)
        && !$past(acc_w, 2) |-> match_irq_first || $past(match_irq_first))
        else $error("wave toggled without match");
endmodule // tmr_pair_sva

bind tmr_pair tmr_pair_sva chk (.*);

// file: sim/pulse_src.sv
`timescale 1ns/1ps
module pulse_src
(
    input wire logic pclk,
    output logic     pulse_in_first,
    output logic     pulse_in_second
);
    initial
    begin
        pulse_in_first = 1'b0;
        pulse_in_second = 1'b0;
    end

    task automatic send(input int n, input logic [1:0] lanes);
        repeat (n)
        begin
            repeat ($urandom_range(2, 5)) @(posedge pclk);
            pulse_in_first <= lanes[0];
            pulse_in_second <= lanes[1];
            repeat ($urandom_range(2, 5)) @(posedge pclk);
            pulse_in_first <= 1'b0;
            pulse_in_second <= 1'b0;
        end
        // settle time covers the two-flop synchroniser and irq latency
        repeat (8) @(posedge pclk);
    endtask
endmodule // pulse_src

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tmr_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pulse_in_first;
    logic        pulse_in_second;
    logic        match_irq_first;
    logic        match_irq_second;
    logic        wave_out_first;
    logic        wave_out_second;
    int          errors;
    int          compares;
    int          irq_seen [2];
    int          cnt_model [2];
    int          k [2];
    int          n;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  a;
    logic [7:0]  v;
    logic [7:0]  mtab [3] = '{8'h03, 8'h01, 8'h03};
    logic [1:0]  ltab [3] = '{2'b11, 2'b11, 2'b10};
    logic [7:0]  rst_addr [6] = '{OFS_COUNT_FIRST, OFS_COUNT_SECOND, OFS_COUNT_COMBINED,
                                  OFS_CLOCK_SELECT, OFS_MODE_CTRL, OFS_OUTPUT_CTRL};

    tmr_pair dut (.*);
    pulse_src src (.*);

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (match_irq_first === 1'b1) irq_seen[0]++;
        if (match_irq_second === 1'b1) irq_seen[1]++;
    end

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        check_reg({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
                       input logic [3:0] s);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 20);
        // a slave that never answers ends the run instead of hanging it
        if (t >= 20)
        begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr8(input logic [7:0] ad, input logic [7:0] d);
        apb(1'b1, ad, {24'h0, d}, 4'h1);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        cnt_model = '{0, 0};
        irq_seen = '{0, 0};
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        errors = 0;
        compares = 0;
        void'($urandom(97020));
        do_reset();
        foreach (rst_addr[i])
        begin
            apb(1'b0, rst_addr[i], 32'h0, 4'h0);
            check_reg(rd, 32'h0);
        end
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, rst_addr[i], 32'h5a, 4'h1);
            check_flag(err, 1'b1);
            apb(1'b0, rst_addr[i], 32'h0, 4'h0);
            check_reg(rd, 32'h0);
        end
        apb(1'b0, 8'h24, 32'h0, 4'h0);
        check_flag(err, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            a = (i % 2) ? OFS_COMPARE_SECOND : OFS_COMPARE_FIRST;
            v = (i < 2) ? 8'h00 : (i < 4) ? 8'hff : 8'($urandom);
            apb(1'b1, a, {24'h0, v}, 4'h1);
            check_flag(err, 1'b0);
            apb(1'b1, a, {24'h0, ~v}, 4'hf);
            check_flag(err, 1'b1);
            apb(1'b0, a, 32'h0, 4'h0);
            check_reg({24'h0, rd[7:0]}, {24'h0, v});
        end
        do_reset();
        wr8(OFS_CLOCK_SELECT, {CSEL_FALLING, CSEL_RISING});
        for (int i = 0; i < 3; i++)
        begin
            wr8(OFS_MODE_CTRL, mtab[i]);
            n = $urandom_range(5, 30);
            src.send(n, ltab[i]);
            for (int c = 0; c < 2; c++)
                if (ltab[i][c] && mtab[i][c]) cnt_model[c] += n;
            apb(1'b0, OFS_COUNT_FIRST, 32'h0, 4'h0);
            check_reg(rd, 32'(cnt_model[0]));
            apb(1'b0, OFS_COUNT_SECOND, 32'h0, 4'h0);
            check_reg(rd, 32'(cnt_model[1]));
            apb(1'b0, OFS_COUNT_COMBINED, 32'h0, 4'h0);
            check_reg(rd, 32'(cnt_model[1] * 256 + cnt_model[0]));
        end
        do_reset();
        k[0] = $urandom_range(1, 5);
        k[1] = $urandom_range(1, 5);
        wr8(OFS_COMPARE_FIRST, 8'(k[0]));
        wr8(OFS_COMPARE_SECOND, 8'(k[1]));
        wr8(OFS_CLOCK_SELECT, 8'h01);
        wr8(OFS_OUTPUT_CTRL, 8'h33);
        // both enabled, clear on match for both channels
        wr8(OFS_MODE_CTRL, 8'h1b);
        n = $urandom_range(12, 24);
        src.send(n, 2'b11);
        check_reg(32'(irq_seen[0]), 32'(n / (k[0] + 1)));
        check_reg(32'(irq_seen[1]), 32'(n / (k[1] + 1)));
        check_flag(wave_out_first, 1'((n / (k[0] + 1)) % 2));
        check_flag(wave_out_second, 1'((n / (k[1] + 1)) % 2));
        // stop the interval run so no clear on match disturbs the divider counts
        wr8(OFS_MODE_CTRL, 8'h00);
        for (int code = 6; code < 16; code++)
        begin
            wr8(OFS_CLOCK_SELECT, 8'(code));
            apb(1'b0, OFS_COUNT_FIRST, 32'h0, 4'h0);
            v = rd[7:0];
            wr8(OFS_MODE_CTRL, 8'h01);
            repeat (4 * ((code == 15) ? 4096 : (1 << (code - 4)))) @(posedge pclk);
            wr8(OFS_MODE_CTRL, 8'h00);
            apb(1'b0, OFS_COUNT_FIRST, 32'h0, 4'h0);
            a = rd[7:0] - v;
            check_flag(a inside {[8'd3:8'd5]}, 1'b1);
        end
        do_reset();
        n = $urandom_range(0, 40);
        // compares loaded while the pair is stopped
        wr8(OFS_COMPARE_FIRST, 8'(n));
        wr8(OFS_COMPARE_SECOND, 8'h01);
        wr8(OFS_CLOCK_SELECT, 8'h01);
        wr8(OFS_OUTPUT_CTRL, 8'h30);
        wr8(OFS_MODE_CTRL, 8'h05);
        src.send(300, 2'b01);
        wr8(OFS_MODE_CTRL, 8'h04);
        src.send(5, 2'b01);
        apb(1'b0, OFS_COUNT_COMBINED, 32'h0, 4'h0);
        check_reg(rd, 32'd300);
        apb(1'b0, OFS_COUNT_FIRST, 32'h0, 4'h0);
        check_reg(rd, 32'd44);
        check_reg(32'(irq_seen[0]), 32'd1);
        check_flag(wave_out_second, 1'b1);
        tally_and_finish();
    end
endmodule // testbench
